// ==== hdl/djc_top.sv ====
// power-up jumper capture and spindle start sequencing for a disk drive
// assumes jumper inputs are static and synchronous; spindle and seek
// hardware answer with level/pulse handshakes below
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - address from the single jumpered header position
// - after speed settles, up to 32 tuning seeks
// - jumpers 2-4 select sectors or address mark
// - jumper 1 absent: spindle starts at power-on
// - jumper 1 present: wait for motor-on command
// - command mode: attention, status bits 8, 9
module djc_top
  import djc_pkg::*;
#(
  parameter int N_SEEKS = djc_pkg::MAX_TUNE_SEEKS
)
(
  input  wire logic                                 i_clock,
  input  wire logic                                 i_rst_b,
  input  wire logic [djc_pkg::ADDR_POSITIONS-1:0]   i_drive_address_header,
  input  wire logic [4:0]                           i_config_select_header,
  input  wire logic                                 i_clear_attention,
  input  wire logic                                 i_start_motor,
  input  wire logic                                 i_speed_ok,
  input  wire logic                                 i_seek_done,
  input  wire logic                                 i_tune_complete,
  output logic      [djc_pkg::ADDR_W-1:0]           o_drive_addr,
  output logic                                      o_addr_valid,
  output logic      [7:0]                           o_sectors_per_track,
  output logic                                      o_address_mark_format,
  output logic                                      o_cmd_start_mode,
  output logic                                      o_attention,
  output logic                                      o_stat_por,
  output logic                                      o_stat_motor_stopped,
  output logic                                      o_spindle_on,
  output logic                                      o_seek_req,
  output logic                                      o_park_outer,
  output logic                                      o_ready
);

  // ----------------------------------------
  // jumper capture
  // ----------------------------------------
  djc_state_t state_r;
  logic       sampled_r;
  logic [5:0] seek_cnt_r;

  function automatic logic [ADDR_W:0] addr_of(input logic [ADDR_POSITIONS-1:0] h);
    logic [ADDR_W:0] r;
    r = {1'b0, ADDR_RST};
    for (int i = 0; i < ADDR_POSITIONS; i++)
      if (h == (ADDR_POSITIONS'(1) << i))
        r = {1'b1, ADDR_W'(i + 1)};
    return r;
  endfunction

  // sampling happens one clock after release so reset flops only take constants
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sampled_r        <= 1'b0;
      o_drive_addr     <= ADDR_RST;
      o_addr_valid     <= 1'b0;
      o_cmd_start_mode <= 1'b0;
    end
    else if (!sampled_r)
    begin
      sampled_r                      <= 1'b1;
      {o_addr_valid, o_drive_addr}   <= addr_of(i_drive_address_header);
      o_cmd_start_mode               <= i_config_select_header[0];
    end
  end

  djc_decode u_decode (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_load      (!sampled_r),
    .i_fmt_bits  ({i_config_select_header[1], i_config_select_header[2],
                   i_config_select_header[3]}),
    .o_spt       (o_sectors_per_track),
    .o_addr_mark (o_address_mark_format)
  );

  // ----------------------------------------
  // host attention and status
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_attention <= 1'b0;
      o_stat_por  <= 1'b0;
    end
    else if (state_r == DJC_SAMPLE)
    begin
      // header bit is read directly here since the mode flop loads this cycle
      o_attention <= i_config_select_header[0];
      o_stat_por  <= i_config_select_header[0];
    end
    else if (i_clear_attention)
    begin
      o_attention <= 1'b0;
      o_stat_por  <= 1'b0;
    end
  end

  // ----------------------------------------
  // spindle and tuning sequence
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r              <= DJC_SAMPLE;
      seek_cnt_r           <= SEEK_RST;
      o_spindle_on         <= 1'b0;
      o_stat_motor_stopped <= 1'b1;
      o_seek_req           <= 1'b0;
      o_park_outer         <= 1'b0;
      o_ready              <= 1'b0;
    end
    else
    begin
      o_seek_req <= 1'b0;
      case (state_r)
        DJC_SAMPLE:
        begin
          if (i_config_select_header[0])
            state_r <= DJC_WAIT_CMD;
          else
          begin
            o_spindle_on         <= 1'b1;
            o_stat_motor_stopped <= 1'b0;
            state_r              <= DJC_SPIN_UP;
          end
        end
        DJC_WAIT_CMD:
        begin
          // start is honoured only once attention has been cleared
          if (i_start_motor && !o_attention)
          begin
            o_spindle_on         <= 1'b1;
            o_stat_motor_stopped <= 1'b0;
            state_r              <= DJC_SPIN_UP;
          end
        end
        DJC_SPIN_UP:
        begin
          if (i_speed_ok)
          begin
            seek_cnt_r <= SEEK_RST;
            state_r    <= DJC_TUNE;
          end
        end
        DJC_TUNE:
        begin
          if (i_tune_complete || seek_cnt_r == 6'(N_SEEKS))
          begin
            o_park_outer <= 1'b1;
            o_ready      <= 1'b1;
            state_r      <= DJC_READY;
          end
          else
          begin
            o_seek_req <= 1'b1;
            seek_cnt_r <= seek_cnt_r + 6'h01;
            state_r    <= DJC_TUNE_WAIT;
          end
        end
        DJC_TUNE_WAIT:
        begin
          if (i_seek_done)
            state_r <= DJC_TUNE;
        end
        DJC_READY:
        begin
          state_r <= DJC_READY;
        end
        default:
        begin
          state_r <= DJC_SAMPLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== hdl/djc_pkg.sv ====
// package for the drive jumper configuration and motor start block
// assumes one 200 MHz clock domain; no register bus
package djc_pkg;

  // ----------------------------------------
  // clock, timing and sizes
  // ----------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int MAX_TUNE_SEEKS = 32;
  localparam int ADDR_POSITIONS = 7;
  localparam int ADDR_W         = 3;

  // ----------------------------------------
  // sector format codes (jumpers 2,3,4 as a 3-bit value)
  // ----------------------------------------
  localparam logic [7:0] SPT_000 = 8'h40;  // 64
  localparam logic [7:0] SPT_001 = 8'h23;  // 35
  localparam logic [7:0] SPT_010 = 8'h0A;  // 10
  localparam logic [7:0] SPT_011 = 8'h13;  // 19
  localparam logic [7:0] SPT_100 = 8'h24;  // 36
  localparam logic [7:0] SPT_101 = 8'h22;  // 34
  localparam logic [7:0] SPT_110 = 8'h57;  // 87
  localparam logic [2:0] FMT_ADDR_MARK = 3'h7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
  localparam logic [7:0]        SPT_RST  = 8'h00;
  localparam logic [5:0]        SEEK_RST = 6'h00;

  typedef enum logic [2:0] {
    DJC_SAMPLE,
    DJC_WAIT_CMD,
    DJC_SPIN_UP,
    DJC_TUNE,
    DJC_TUNE_WAIT,
    DJC_READY
  } djc_state_t;

endpackage

// ==== hdl/djc_decode.sv ====
// sector format decoder for the configuration header
// jumper bits come straight from the header; this block captures them itself while i_load is high
`timescale 1ns/1ps
`default_nettype none
module djc_decode
  import djc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_load,
  input  wire logic [2:0] i_fmt_bits,
  output logic      [7:0] o_spt,
  output logic            o_addr_mark
);

  function automatic logic [7:0] spt_of(input logic [2:0] f);
    case (f)
      3'h0:    spt_of = SPT_000;
      3'h1:    spt_of = SPT_001;
      3'h2:    spt_of = SPT_010;
      3'h3:    spt_of = SPT_011;
      3'h4:    spt_of = SPT_100;
      3'h5:    spt_of = SPT_101;
      3'h6:    spt_of = SPT_110;
      default: spt_of = SPT_RST;
    endcase
  endfunction

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_spt       <= SPT_RST;
      o_addr_mark <= 1'b0;
    end
    else if (i_load)
    begin
      o_spt       <= spt_of(i_fmt_bits);
      o_addr_mark <= (i_fmt_bits == FMT_ADDR_MARK);
    end
  end

endmodule
`default_nettype wire

// ==== sim/djc_properties.sv ====
// port assertions for djc_top
// bound into djc_top; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module djc_properties
  import djc_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic       i_start_motor,
  input wire logic [2:0] o_drive_addr,
  input wire logic       o_addr_valid,
  input wire logic [7:0] o_sectors_per_track,
  input wire logic       o_address_mark_format,
  input wire logic       o_cmd_start_mode,
  input wire logic       o_attention,
  input wire logic       o_stat_por,
  input wire logic       o_stat_motor_stopped,
  input wire logic       o_spindle_on,
  input wire logic       o_seek_req,
  input wire logic       o_park_outer,
  input wire logic       o_ready
);
  // ----
  // checks
  // ----
  // counts edges since release, holding at 3; the jumpers land on the first one
  logic [1:0] up_r;
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence start_taken;
    up_r != 2'h0 && o_cmd_start_mode && !o_attention && !o_spindle_on && i_start_motor;
  endsequence
  held_cfg_a: assert property (up_r == 2'h3 |-> $stable({o_drive_addr, o_cmd_start_mode}))
    else $error("settings moved");
  fmt_mark_a: assert property (up_r != 2'h0 |-> o_address_mark_format == !o_sectors_per_track)
    else $error("format flag mismatch");
  addr_valid_a: assert property (o_addr_valid == (o_drive_addr != 3'h0))
    else $error("address flag mismatch");
  auto_spin_a: assert property (up_r != 2'h0 && !o_cmd_start_mode |-> o_spindle_on)
    else $error("spindle not started");
  power_attn_a: assert property (up_r == 2'h1 && o_cmd_start_mode |-> o_attention && o_stat_por)
    else $error("power-up status missing");
  motor_start_a: assert property (start_taken |=> o_spindle_on && !o_stat_motor_stopped)
    else $error("start not taken");
  seek_pulse_a: assert property (o_seek_req |=> !o_seek_req)
    else $error("seek request too long");
  park_ready_a: assert property ($rose(o_park_outer) |-> o_ready && !o_seek_req)
    else $error("park without ready");
endmodule
bind djc_top djc_properties u_props (.*);
`default_nettype wire

// ==== sim/djc_host_model.sv ====
// host controller and spindle stand-in for djc_top
// drives on falling edges; i_lag sets spin-up time
`timescale 1ns/1ps
`default_nettype none
module djc_host_model
(
  input  wire logic       i_clock,
  input  wire logic [3:0] i_lag,
  input  wire logic       i_attention,
  input  wire logic       i_spindle_on,
  input  wire logic       i_seek_req,
  output var  logic       o_clear_attention = 1'b0,
  output var  logic       o_start_motor = 1'b0,
  output var  logic       o_speed_ok = 1'b0,
  output var  logic       o_seek_done = 1'b0
);
  logic [3:0] spin_r = 4'h0;
  always @(negedge i_clock)
  begin
    o_clear_attention <= i_attention;
    // start only once attention has dropped, never alongside the clear
    o_start_motor <= o_clear_attention && !i_attention;
    if (!i_spindle_on) spin_r <= 4'h0;
    else if (spin_r != 4'hf) spin_r <= spin_r + 4'h1;
    o_speed_ok <= i_spindle_on && spin_r >= i_lag;
    o_seek_done <= i_seek_req;
  end
endmodule
`default_nettype wire

// ==== sim/djc_top_test.sv ====
// self-checking bench for djc_top
// one power-up per run, address jumpers mostly from an lfsr, config jumpers 1-4 from the run index and jumper 5 from the lfsr
`timescale 1ns/1ps
`default_nettype none
module djc_top_test;
  import djc_pkg::*;
  localparam int NS = 3;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        tune = 1'b0;
  logic [6:0]  addr_j = 7'h01;
  logic [4:0]  cfg_j = 5'h00;
  logic [3:0]  lag = 4'h0;
  logic [2:0]  ea;
  logic [5:0]  nseek;
  logic [14:0] n;
  logic [31:0] lf = 32'h0000_e94c;
  logic [7:0]  spt [8] = '{8'h40, 8'h23, 8'h0a, 8'h13, 8'h24, 8'h22, 8'h57, 8'h00};
  logic [14:0] notes [$];
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  wire  [2:0]  o_drive_addr;
  wire  [7:0]  o_sectors_per_track;
  wire         clr, start, spd, sdone, o_addr_valid, o_address_mark_format;
  wire         o_cmd_start_mode, o_attention, o_spindle_on, o_seek_req, o_park_outer, o_ready;
  djc_top #(.N_SEEKS(NS)) dut (.i_clock, .i_rst_b, .i_drive_address_header(addr_j),
    .i_config_select_header(cfg_j), .i_clear_attention(clr), .i_start_motor(start),
    .i_speed_ok(spd), .i_seek_done(sdone), .i_tune_complete(tune), .o_drive_addr,
    .o_addr_valid, .o_sectors_per_track, .o_address_mark_format, .o_cmd_start_mode,
    .o_attention, .o_stat_por(), .o_stat_motor_stopped(), .o_spindle_on, .o_seek_req,
    .o_park_outer, .o_ready);
  djc_host_model host (.i_clock, .i_lag(lag), .i_attention(o_attention),
    .i_spindle_on(o_spindle_on), .i_seek_req(o_seek_req), .o_clear_attention(clr),
    .o_start_motor(start), .o_speed_ok(spd), .o_seek_done(sdone));
  always #2.5 i_clock = ~i_clock;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_cfg(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_seek(input logic [5:0] got, input logic [5:0] exp);
    cmp_cfg({9'h000, got}, {9'h000, exp});
  endtask
  task automatic conclude;
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b) nseek <= 6'h00;
    else if (o_seek_req === 1'b1) nseek <= nseek + 6'h01;
  // the oldest note belongs to the power-up that just came ready
  always @(posedge o_ready)
  begin
    #1;
    n = notes.pop_front();
    cmp_cfg({o_drive_addr, o_addr_valid, o_sectors_per_track, o_address_mark_format,
      o_cmd_start_mode, o_park_outer}, {n[14:1], 1'b1});
    cmp_seek(nseek, n[0] ? 6'h00 : 6'(NS));
  end
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    // runs 0..7 auto start, 8..15 command start; every format code once in each half
    for (int r = 0; r < 16; r++)
    begin
      @(negedge i_clock);
      i_rst_b = 1'b0;
      lf = nx(lf);
      addr_j = (r % 3 == 0) ? 7'h01 << (r % 7) : lf[6:0];
      cfg_j = {lf[9], r[0], r[1], r[2], r[3]};
      lag = lf[13:10];
      tune = (r == 15);
      ea = 3'h0;
      for (int k = 0; k < 7; k++) if (addr_j == 7'h01 << k) ea = 3'(k + 1);
      notes.push_back({ea, ea != 3'h0, spt[r[2:0]], r[2:0] == 3'h7, r[3], tune});
      repeat (6) @(negedge i_clock);
      i_rst_b = 1'b1;
      repeat (2) @(negedge i_clock);
      addr_j = ~addr_j;
      cfg_j = ~cfg_j;
      repeat (300) if (o_ready !== 1'b1) @(negedge i_clock);
      // a power-up that never comes ready must not slip through as a pass
      if (o_ready !== 1'b1) fails++;
      repeat (3) @(negedge i_clock);
    end
    conclude();
  end
endmodule
`default_nettype wire
